// ---- lrf_pkg.sv ----
// Package for the receive output formatter: constants and carrier types
//----------------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------------
package lrf_pkg;

  localparam int NUM_CH = 4;
  // Control lines carried from the system side: rate, rail, invert per channel
  localparam int CTRL_W = 3;
  // Pipeline depth from line pulse to rail output, in link clocks
  localparam int RAIL_LATENCY = 4;
  // Saturation point of the mode-age helper counter
  localparam logic [2:0] AGE_MAX = 3'h7;
  // Reset values
  localparam logic SYNC_RST = 1'h0;
  localparam logic RAIL_RST = 1'h0;
  localparam logic LAST_NEG_RST = 1'h0;

  // Per-channel control as seen by the link logic
  typedef struct packed {
    logic hdb3;    // Four-zero substitution rules (E3)
    logic single;  // Single-rail output with decoder active
    logic invert;  // Present data on the falling clock edge
  } lrf_ctrl_type;

  // One stage of the receive pipeline
  typedef struct packed {
    logic pos;     // Positive line pulse
    logic neg;     // Negative line pulse
    logic cv;      // Code violation flagged for this bit
  } lrf_stage_type;

  localparam lrf_ctrl_type CTRL_RST = '{hdb3: 1'h0, single: 1'h0,
                                        invert: 1'h0};
  localparam lrf_stage_type STAGE_RST = '{pos: 1'h0, neg: 1'h0, cv: 1'h0};

endpackage

// ---- lrf_rx_formatter.sv ----
// Four-channel receive output formatter with line-code decoder
`timescale 1ns/1ps
module lrf_rx_formatter (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic controlModeSelect,
  input wire logic rxClockInvert,
  input wire logic rxClockInvertOpen,
  input wire logic railSelectOrChipSelect,
  input wire logic [3:0] hostInvertBit,
  input wire logic [3:0] channelRailSelectBit,
  input wire logic [3:0] lineRateE3,
  input wire logic [3:0] recClk,
  input wire logic [3:0] lineInPositiveLeg,
  input wire logic [3:0] lineInNegativeLeg,
  output logic [3:0] recoveredClockOut,
  output logic [3:0] positiveRailOut,
  output logic [3:0] negativeRailOut
);

  //--------------------------------------------------------------------
  // System-side pin synchronisers
  //--------------------------------------------------------------------
  localparam int PIN_W = 4 + 3 * lrf_pkg::NUM_CH;

  logic [PIN_W-1:0] pinMeta_r;
  logic [PIN_W-1:0] pinSync_r;
  wire [PIN_W-1:0] pinRaw = {controlModeSelect, rxClockInvert,
                             rxClockInvertOpen, railSelectOrChipSelect,
                             hostInvertBit, channelRailSelectBit,
                             lineRateE3};

  // Two flops before any logic reads a pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  wire hostMode = pinSync_r[PIN_W-1];
  wire invPin = pinSync_r[PIN_W-2];
  wire invOpen = pinSync_r[PIN_W-3];
  wire railPin = pinSync_r[PIN_W-4];
  wire [3:0] hostInv = pinSync_r[11:8];
  wire [3:0] hostRail = pinSync_r[7:4];
  wire [3:0] rateE3 = pinSync_r[3:0];
  // Floating invert input reads high
  wire invPinEff = invPin | invOpen;

  //--------------------------------------------------------------------
  // Per-channel control selection and link-domain logic
  //--------------------------------------------------------------------
  lrf_pkg::lrf_ctrl_type ctrlSys_r [lrf_pkg::NUM_CH];

  genvar i;
  generate
    for (i = 0; i < lrf_pkg::NUM_CH; i++) begin : g_ch
      lrf_pkg::lrf_ctrl_type ctrlNxt;
      lrf_pkg::lrf_ctrl_type ctrlMeta_r;
      lrf_pkg::lrf_ctrl_type ctrlLink_r;
      lrf_pkg::lrf_ctrl_type ctrlPrev_r;
      lrf_pkg::lrf_stage_type st0_r;
      lrf_pkg::lrf_stage_type st1_r;
      lrf_pkg::lrf_stage_type st2_r;
      lrf_pkg::lrf_stage_type st0Nxt;
      lrf_pkg::lrf_stage_type st2Nxt;
      logic lastNeg_r;
      logic seen_r;
      logic posRail_r;
      logic negRail_r;
      logic [2:0] age_r;

      // Pin mode uses shared invert and rail pins; host mode uses per-channel bits; rate bits are per channel in both
      assign ctrlNxt.invert = hostMode ? hostInv[i] : invPinEff;
      assign ctrlNxt.single = hostMode ? hostRail[i] : railPin;
      assign ctrlNxt.hdb3 = rateE3[i];

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ctrlSys_r[i] <= lrf_pkg::CTRL_RST;
        end else begin
          ctrlSys_r[i] <= ctrlNxt;
        end
      end

      // Level crossing of the control word into the link clock
      always_ff @(posedge recClk[i] or negedge nrst) begin
        if (!nrst) begin
          ctrlMeta_r <= lrf_pkg::CTRL_RST;
          ctrlLink_r <= lrf_pkg::CTRL_RST;
        end else begin
          ctrlMeta_r <= ctrlSys_r[i];
          ctrlLink_r <= ctrlMeta_r;
        end
      end

      // Line pulse decode and substitution recognition
      wire pIn = lineInPositiveLeg[i];
      wire nIn = lineInNegativeLeg[i];
      wire markIn = pIn | nIn;
      wire violIn = markIn & seen_r & (nIn == lastNeg_r);
      wire st0Zero = ~st0_r.pos & ~st0_r.neg;
      wire st1Zero = ~st1_r.pos & ~st1_r.neg;
      wire patOk = ctrlLink_r.hdb3 ? (st0Zero & st1Zero) : st0Zero;
      wire substIn = ctrlLink_r.single & violIn & patOk;
      wire cvIn = ctrlLink_r.single & violIn & ~patOk;
      wire clrB3 = substIn & ~ctrlLink_r.hdb3;
      wire clrHd = substIn & ctrlLink_r.hdb3;
      wire st2Mark = st2_r.pos | st2_r.neg;

      // Substitution pulses enter the pipe as zeros
      assign st0Nxt = substIn ? lrf_pkg::STAGE_RST :
                      lrf_pkg::lrf_stage_type'{pos: pIn, neg: nIn,
                                               cv: cvIn};
      // Three-zero rule clears its bipolar pulse two bits back
      assign st2Nxt = clrB3 ? lrf_pkg::STAGE_RST : st1_r;
      // Single-rail decoded data, or dual-rail positive pulses
      wire posNxt = ctrlLink_r.single ? (st2Mark & ~clrHd)
                                      : st2_r.pos;
      // Violation pulse, or dual-rail negative pulses
      wire negNxt = ctrlLink_r.single ? (st2_r.cv & ~clrHd)
                                      : st2_r.neg;

      // Receive pipeline, always on the rising recovered-clock edge
      always_ff @(posedge recClk[i] or negedge nrst) begin
        if (!nrst) begin
          st0_r <= lrf_pkg::STAGE_RST;
          st1_r <= lrf_pkg::STAGE_RST;
          st2_r <= lrf_pkg::STAGE_RST;
          posRail_r <= lrf_pkg::RAIL_RST;
          negRail_r <= lrf_pkg::RAIL_RST;
        end else begin
          st0_r <= st0Nxt;
          st1_r <= st0_r;
          st2_r <= st2Nxt;
          posRail_r <= posNxt;
          negRail_r <= negNxt;
        end
      end

      // Polarity of the last pulse seen, for violation detection
      always_ff @(posedge recClk[i] or negedge nrst) begin
        if (!nrst) begin
          lastNeg_r <= lrf_pkg::LAST_NEG_RST;
          seen_r <= 1'h0;
        end else if (markIn) begin
          lastNeg_r <= nIn;
          seen_r <= 1'h1;
        end
      end

      // Cycles since the link control word last changed
      always_ff @(posedge recClk[i] or negedge nrst) begin
        if (!nrst) begin
          ctrlPrev_r <= lrf_pkg::CTRL_RST;
          age_r <= 3'h0;
        end else begin
          ctrlPrev_r <= ctrlLink_r;
          if (ctrlPrev_r != ctrlLink_r) begin
            age_r <= 3'h0;
          end else if (age_r != lrf_pkg::AGE_MAX) begin
            age_r <= age_r + 3'h1;
          end
        end
      end

      // Rails change on the rising internal edge; inverting the output
      // clock places that change on its falling edge
      assign recoveredClockOut[i] = recClk[i] ^ ctrlLink_r.invert;
      assign positiveRailOut[i] = posRail_r;
      assign negativeRailOut[i] = negRail_r;

      wire stable = (age_r >= 3'h5);

      a_dual_pos_path: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && !ctrlLink_r.single |-> posRail_r == $past(pIn, 4))
        else $error("dual-rail positive output lost a line pulse");

      a_dual_neg_path: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && !ctrlLink_r.single |-> negRail_r == $past(nIn, 4))
        else $error("dual-rail negative output lost a line pulse");

      a_cv_on_neg: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && ctrlLink_r.single && $past(cvIn, 4) |-> negRail_r)
        else $error("code violation not shown on negative output");

      a_cv_one_pulse: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && ctrlLink_r.single && negRail_r |-> $past(cvIn, 4))
        else $error("negative output high without a violation");

      a_subst_zeroed: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && ctrlLink_r.single && $past(substIn, 4) |-> !posRail_r)
        else $error("substitution pulse reached the data output");

      a_single_data: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && ctrlLink_r.single && posRail_r |-> $past(markIn, 4))
        else $error("data output high without a line pulse");

      a_clock_follow: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        recoveredClockOut[i] == (recClk[i] ^ ctrlLink_r.invert))
        else $error("clock output does not follow recovered clock");

      a_host_rail_bit: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        hostMode |=> ctrlSys_r[i].single == $past(hostRail[i]))
        else $error("host rail bit not applied");

      a_host_inv_bit: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        hostMode |=> ctrlSys_r[i].invert == $past(hostInv[i]))
        else $error("host invert bit not applied");

      a_pin_invert: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !hostMode && (invPin || invOpen) |=> ctrlSys_r[i].invert)
        else $error("invert pin not applied to every channel");

      a_pin_rail: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !hostMode |=> ctrlSys_r[i].single == $past(railPin))
        else $error("rail select pin not applied");

      a_pin_inv_eff: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !hostMode |=> ctrlSys_r[i].invert == $past(invPinEff))
        else $error("effective invert level not applied");

      //----------------------------------------------------------------
      // Link-domain checks on the decoder and the crossing
      //----------------------------------------------------------------

      // The link word is the system word two link edges late
      a_link_ctrl_cross: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        ctrlLink_r == $past(ctrlSys_r[i], 2))
        else $error("control word did not cross to the link clock");

      // Three-zero rule: the cleared bipolar bit never reaches the rails
      a_b3_pair_clear: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && $past(clrB3, 2) |-> !posRail_r && !negRail_r)
        else $error("three-zero substitution bit reached the rails");

      // Four-zero rule: the bit three back is masked at the rails
      a_hd_pair_clear: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && $past(clrHd) |-> !posRail_r && !negRail_r)
        else $error("four-zero substitution bit reached the rails");

      // A violation always rides on a data one
      a_cv_with_data: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && ctrlLink_r.single && negRail_r |-> posRail_r)
        else $error("violation flagged without a data one");

      // A lone violation lasts one link clock
      a_cv_single_clk: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && ctrlLink_r.single && negRail_r && !$past(cvIn, 3)
        |=> !negRail_r)
        else $error("violation pulse longer than one clock");

      // Four-zero rule needs two zeros before the violation
      a_hd_rule: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        ctrlLink_r.single && ctrlLink_r.hdb3 && violIn &&
        !(st0Zero && st1Zero) |-> cvIn)
        else $error("four-zero rule misread a violation");

      // Three-zero rule needs one zero before the violation
      a_b3_rule: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        ctrlLink_r.single && !ctrlLink_r.hdb3 && violIn && st0Zero
        |-> substIn)
        else $error("three-zero substitution not recognised");

      // Dual-rail keeps the decoder out of the path
      a_dual_no_decode: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        !ctrlLink_r.single |-> !cvIn && !substIn)
        else $error("decoder active in dual-rail mode");

      // Dual-rail with no line pulse gives quiet rails
      a_dual_quiet: assert property (
        @(posedge recClk[i]) disable iff (!nrst)
        stable && !ctrlLink_r.single && !$past(markIn, 4)
        |-> !posRail_r && !negRail_r)
        else $error("dual-rail output pulsed without a line pulse");
    end
  endgenerate

  //--------------------------------------------------------------------
  // System-side checks
  //--------------------------------------------------------------------

  // Every pin passes exactly two flops once reset has been gone a while
  a_pin_sync_depth: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $past(nrst) && $past(nrst, 2) |-> pinSync_r == $past(pinRaw, 2))
    else $error("pin synchroniser depth is wrong");

  // The shared invert pin reaches the outer channels alike
  a_pin_inv_shared: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !hostMode |=> ctrlSys_r[0].invert == ctrlSys_r[3].invert)
    else $error("shared invert pin differs between channels");

  a_open_reads_high: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !hostMode && invOpen |=> ctrlSys_r[0].invert && ctrlSys_r[3].invert)
    else $error("unconnected invert input did not read high");

endmodule

// ---- lrf_term_model.sv ----
// Terminal equipment model that captures the receive rails
`timescale 1ns/1ps
module lrf_term_model (
  input wire logic [3:0] recoveredClockOut,
  input wire logic [3:0] positiveRailOut,
  input wire logic [3:0] negativeRailOut,
  output logic [3:0] capPos,
  output logic [3:0] capNeg
);
  // One capture per channel on the rising edge of its clock output
  for (genvar i = 0; i < 4; i++) begin : g_ch
    always @(posedge recoveredClockOut[i]) begin
      capPos[i] <= positiveRailOut[i];
      capNeg[i] <= negativeRailOut[i];
    end
  end
endmodule

// ---- lrf_rx_formatter_tb.sv ----
// Testbench for the receive output formatter
`timescale 1ns/1ps
module lrf_rx_formatter_tb;
  logic clk_sys = 1'h0;
  logic linkClk = 1'h0;
  logic nrst = 1'h0;
  logic hostMode = 1'h0;
  logic invPin = 1'h0;
  logic invOpen = 1'h0;
  logic railPin = 1'h0;
  logic [3:0] hostInv = 4'h0;
  logic [3:0] hostRail = 4'h0;
  logic [3:0] rateE3 = 4'h0;
  logic [3:0] linePos = 4'h0;
  logic [3:0] lineNeg = 4'h0;
  logic [3:0] clkOut;
  logic [3:0] posOut;
  logic [3:0] negOut;
  logic [3:0] capPos;
  logic [3:0] capNeg;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [1:0] expQ[$];

  //--------------------------------------------------
  // Clocks, design and far-end model
  //--------------------------------------------------
  always #5 clk_sys = ~clk_sys;
  // Link clock offset so its edges never meet the system clock
  initial begin
    #3;
    forever #80 linkClk = ~linkClk;
  end

  lrf_rx_formatter lrf_rx_formatter_inst (.clk_sys(clk_sys), .nrst(nrst),
    .controlModeSelect(hostMode), .rxClockInvert(invPin),
    .rxClockInvertOpen(invOpen), .railSelectOrChipSelect(railPin),
    .hostInvertBit(hostInv), .channelRailSelectBit(hostRail),
    .lineRateE3(rateE3), .recClk({4{linkClk}}),
    .lineInPositiveLeg(linePos), .lineInNegativeLeg(lineNeg),
    .recoveredClockOut(clkOut), .positiveRailOut(posOut),
    .negativeRailOut(negOut));

  lrf_term_model lrf_term_model_inst (.recoveredClockOut(clkOut),
    .positiveRailOut(posOut), .negativeRailOut(negOut),
    .capPos(capPos), .capNeg(capNeg));

  //--------------------------------------------------
  // Tasks
  //--------------------------------------------------
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Line symbols + - 0, expected rail symbols + - 0 and v (data plus flag)
  task automatic seq(input string s, input string e);
    string t;
    t = {s, "000000"};
    e = {e, "000000"};
    expQ.delete();
    for (int k = 0; k < t.len(); k++) begin
      @(posedge linkClk);
      #1;
      linePos = {4{t[k] == "+"}};
      lineNeg = {4{t[k] == "-"}};
      expQ.push_back({e[k] == "+" || e[k] == "v", e[k] == "-" || e[k] == "v"});
      if (expQ.size() > 5) begin
        chk(capPos, {4{expQ[0][1]}});
        chk(capNeg, {4{expQ[0][0]}});
        void'(expQ.pop_front());
      end
    end
  endtask

  // Apply controls, reset, then idle bits until controls settle
  task automatic cfg(input logic h, input logic ip, input logic io,
                     input logic rp, input logic [3:0] hi,
                     input logic [3:0] hr, input logic [3:0] e3);
    @(posedge linkClk);
    #1;
    {hostMode, invPin, invOpen, railPin} = {h, ip, io, rp};
    {hostInv, hostRail, rateE3} = {hi, hr, e3};
    nrst = 1'h0;
    repeat (4) @(posedge linkClk);
    #1;
    nrst = 1'h1;
    seq("0000", "0000");
  endtask

  // Clock output seen while the link clock is high
  task automatic ckc(input logic [3:0] exp);
    @(posedge linkClk);
    #40;
    chk(clkOut, exp);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  //--------------------------------------------------
  // Timeout and test sequence
  //--------------------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    // Pin mode dual rail, host bits set but ignored
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 4'hF, 4'hF, 4'h0);
    ckc(4'hF);
    seq("+0-+-00+--++", "+0-+-00+--++");
    // Pin invert drives all channels
    cfg(1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 4'h0, 4'h0);
    ckc(4'h0);
    seq("+-0+-", "+-0+-");
    // Open invert pin reads high
    cfg(1'h0, 1'h0, 1'h1, 1'h0, 4'h0, 4'h0, 4'h0);
    ckc(4'h0);
    // Host mode, per-channel invert, dual rail despite rail pin high
    cfg(1'h1, 1'h0, 1'h0, 1'h1, 4'hA, 4'h0, 4'h0);
    ckc(4'h5);
    seq("-+0+-", "-+0+-");
    // Pin mode single rail, three-zero substitution
    cfg(1'h0, 1'h0, 1'h0, 1'h1, 4'h0, 4'h0, 4'h0);
    seq("+-0-", "+000");
    seq("+-00-", "++000");
    seq("++", "+v");
    // Host mode single rail, four-zero substitution
    cfg(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 4'hF, 4'hF);
    seq("+-00-", "+0000");
    seq("+000+", "+0000");
    seq("-+-", "+++");
    tally_and_finish();
  end
endmodule
